//--- verilog/qct_pkg.sv
// Shared constants and types for the four-channel counter/timer.
// Assumes a single synchronous system clock and host inputs sampled on it.
package qct_pkg;
  // ***************************************************
  // Channel count and setup word bit positions
  // ***************************************************
  localparam int QCT_NCH = 4; // Channel count
  localparam int CW_IE = 7; // Interrupt enable
  localparam int CW_MODE = 6; // 1 = counter mode
  localparam int CW_PRE = 5; // 1 = divide by 256
  localparam int CW_SLOPE = 4; // 1 = rising edge active
  localparam int CW_TRIG = 3; // 1 = wait for trigger edge
  localparam int CW_TCF = 2; // Reload value follows
  localparam int CW_SRST = 1; // Software stop
  localparam int CW_CTRL = 0; // Marks a setup word
  // ***************************************************
  // Values
  // ***************************************************
  localparam logic [7:0] PRE16_LAST = 8'h0f; // Last prescaler state, /16
  localparam logic [7:0] PRE256_LAST = 8'hff; // Last prescaler state, /256
  localparam logic [7:0] INTERRUPT_RETURN_INSTRUCTION_FIRST = 8'hed; // First byte of return
  localparam logic [7:0] INTERRUPT_RETURN_INSTRUCTION_SECOND = 8'h4d; // Second byte of return
  localparam logic [7:0] BYTE_RESET = 8'h00; // Counter, reload, bus reset
  localparam logic [7:0] COUNT_LAST = 8'h01; // Count that reaches zero
  localparam logic [4:0] VEC_RESET = 5'h00; // Vector upper bits reset
  // Host bus carrier
  typedef struct packed {
    logic chip_enable_n;
    logic io_request_n;
    logic read_n;
    logic opcode_fetch_n;
    logic channel_select_hi;
    logic channel_select_lo;
    logic [7:0] data;
  } qct_bus_t;
  // Decoded channel settings
  typedef struct packed {
    logic ie;
    logic counter_mode;
    logic pre256;
    logic rising;
    logic ext_start;
  } qct_setup_t;
  localparam qct_setup_t SETUP_RESET = '0; // All off after reset
endpackage : qct_pkg

//--- verilog/qct_core.sv
// Four-channel down-counter/timer with daisy-chained vectored interrupt.
// Assumes host bus and trigger inputs are synchronous to sys_clk.
`timescale 1ns/10ps
module qct_core (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire qct_pkg::qct_bus_t host_bus,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic [3:0] ext_count_trigger,
  output logic [2:0] zero_count_pulse,
  output logic int_req_n_out,
  output logic int_req_n_oe,
  input wire logic chain_enable_in,
  output logic chain_enable_out
);
  import qct_pkg::*;

  // ***************************************************
  // Helpers
  // ***************************************************
  // Edge of chosen polarity between two samples
  function automatic logic active_edge(input logic prev, input logic cur, input logic rising);
    return rising ? (cur & ~prev) : (~cur & prev);
  endfunction : active_edge

  // First pending channel not shadowed by a serviced one
  function automatic logic [2:0] pick_grant(input logic [3:0] p, input logic [3:0] s);
    logic blocked;
    logic [2:0] r;
    blocked = 1'b0;
    r = 3'b000;
    for (int i = 0; i < QCT_NCH; i++) begin
      blocked = blocked | s[i];
      if (!blocked && p[i] && !r[2]) begin
        r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction : pick_grant

  // ***************************************************
  // Bus decode
  // ***************************************************
  logic [1:0] sel; // Addressed channel
  logic io_sel; // Chip I/O cycle
  logic wr_act; // Write cycle active
  logic rd_act; // Read cycle active
  logic ack_act; // Interrupt acknowledge active
  logic fetch; // Opcode fetch active
  logic wr_prev; // Previous write level
  logic ack_prev; // Previous acknowledge level
  logic fetch_prev; // Previous fetch level
  logic wr_stb; // First cycle of a write
  logic ack_stb; // First cycle of acknowledge
  logic fetch_end; // Fetch just finished
  logic [7:0] last_op; // Opcode seen on last fetch
  logic ed_seen; // Return first byte fetched
  logic is_tc; // Write is a reload value
  logic is_ctl; // Write is a setup word
  logic is_vec; // Write is the vector

  assign sel = {host_bus.channel_select_hi, host_bus.channel_select_lo};
  assign io_sel = !host_bus.chip_enable_n && !host_bus.io_request_n && host_bus.opcode_fetch_n;
  assign wr_act = io_sel && host_bus.read_n;
  assign rd_act = io_sel && !host_bus.read_n;
  assign ack_act = !host_bus.opcode_fetch_n && !host_bus.io_request_n;
  assign fetch = !host_bus.opcode_fetch_n && !host_bus.read_n && host_bus.io_request_n;
  assign wr_stb = wr_act && !wr_prev;
  assign ack_stb = ack_act && !ack_prev;
  assign fetch_end = fetch_prev && !fetch;

  // Strobe history; a long write acts only once
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_prev <= 1'b0;
      ack_prev <= 1'b0;
      fetch_prev <= 1'b0;
    end else begin
      wr_prev <= wr_act;
      ack_prev <= ack_act;
      fetch_prev <= fetch;
    end
  end

  // Opcode watch for the return sequence
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      last_op <= BYTE_RESET;
      ed_seen <= 1'b0;
    end else begin
      if (fetch) begin
        last_op <= host_bus.data;
      end
      if (fetch_end) begin
        ed_seen <= (last_op == INTERRUPT_RETURN_INSTRUCTION_FIRST);
      end
    end
  end

  // ***************************************************
  // Setup, reload and vector storage
  // ***************************************************
  qct_setup_t setup [QCT_NCH]; // Per-channel settings
  logic [3:0] tc_follow; // Next write is reload value
  logic [7:0] reload_value [QCT_NCH]; // Reload per channel
  logic [4:0] vector; // Shared vector upper bits
  logic [3:0] slope_kick; // Slope change acts as edge

  assign is_tc = tc_follow[sel];
  assign is_ctl = !is_tc && host_bus.data[CW_CTRL];
  assign is_vec = !is_tc && !host_bus.data[CW_CTRL] && (sel == 2'b00);

  // Host writes into setup, reload and vector
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tc_follow <= 4'h0;
      vector <= VEC_RESET;
      for (int c = 0; c < QCT_NCH; c++) begin
        setup[c] <= SETUP_RESET;
        reload_value[c] <= BYTE_RESET;
      end
    end else if (wr_stb) begin
      if (is_tc) begin
        reload_value[sel] <= host_bus.data;
        tc_follow[sel] <= 1'b0;
      end else if (is_ctl) begin
        setup[sel].ie <= host_bus.data[CW_IE];
        setup[sel].counter_mode <= host_bus.data[CW_MODE];
        setup[sel].pre256 <= host_bus.data[CW_PRE];
        setup[sel].rising <= host_bus.data[CW_SLOPE];
        setup[sel].ext_start <= host_bus.data[CW_TRIG];
        tc_follow[sel] <= host_bus.data[CW_TCF];
      end else if (is_vec) begin
        vector <= host_bus.data[7:3];
      end
    end
  end

  // ***************************************************
  // Counting
  // ***************************************************
  logic [7:0] count [QCT_NCH]; // Remaining count, 0 means 256
  logic [7:0] presc [QCT_NCH]; // Prescaler per channel
  logic [3:0] running; // Channel decrementing
  logic [3:0] armed; // Timer waiting for trigger
  logic [3:0] trig_prev; // Previous trigger samples
  logic [3:0] edge_hit; // Active trigger edge
  logic [3:0] dec; // Decrement this cycle
  logic [3:0] zc; // Zero count this cycle

  // Edge, decrement and zero decode per channel
  always_comb begin
    for (int c = 0; c < QCT_NCH; c++) begin
      slope_kick[c] = wr_stb && is_ctl && (sel == 2'(c))
        && (host_bus.data[CW_SLOPE] != setup[c].rising);
      edge_hit[c] = active_edge(trig_prev[c], ext_count_trigger[c], setup[c].rising)
        || slope_kick[c];
      dec[c] = setup[c].counter_mode ? edge_hit[c]
        : (presc[c] == (setup[c].pre256 ? PRE256_LAST : PRE16_LAST));
      zc[c] = running[c] && dec[c] && (count[c] == COUNT_LAST);
    end
  end

  // Trigger history; inputs are already synchronous
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_prev <= 4'h0;
    end else begin
      trig_prev <= ext_count_trigger;
    end
  end

  // Down-counters with prescalers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      running <= 4'h0;
      armed <= 4'h0;
      for (int c = 0; c < QCT_NCH; c++) begin
        count[c] <= BYTE_RESET;
        presc[c] <= BYTE_RESET;
      end
    end else begin
      for (int c = 0; c < QCT_NCH; c++) begin
        if (wr_stb && is_ctl && (sel == 2'(c)) && host_bus.data[CW_SRST]) begin
          running[c] <= 1'b0;
          armed[c] <= 1'b0;
          presc[c] <= BYTE_RESET;
        end else if (wr_stb && is_tc && (sel == 2'(c)) && !running[c]) begin
          // Idle channel loads at once; busy one waits for zero
          count[c] <= host_bus.data;
          presc[c] <= BYTE_RESET;
          if (setup[c].counter_mode || !setup[c].ext_start) begin
            running[c] <= 1'b1;
          end else begin
            armed[c] <= 1'b1;
          end
        end else if (armed[c] && edge_hit[c]) begin
          armed[c] <= 1'b0;
          running[c] <= 1'b1;
          presc[c] <= BYTE_RESET;
        end else if (running[c]) begin
          if (!setup[c].counter_mode) begin
            presc[c] <= dec[c] ? BYTE_RESET : presc[c] + 8'h01;
          end
          if (zc[c]) begin
            count[c] <= reload_value[c];
          end else if (dec[c]) begin
            count[c] <= count[c] - 8'h01;
          end
        end
      end
    end
  end

  // Zero-count pulses, channel 3 has none
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      zero_count_pulse <= 3'b000;
    end else begin
      zero_count_pulse <= zc[2:0];
    end
  end

  // ***************************************************
  // Interrupt chain
  // ***************************************************
  logic [3:0] pend; // Waiting for acknowledge
  logic [3:0] serv; // Under service
  logic [2:0] grant; // Valid bit and winning channel
  logic grant_ok; // We may answer acknowledge
  logic [2:0] serv_top; // Highest serviced channel
  logic interrupt_return_instruction_stb; // Return sequence completed
  logic ack_drive; // Vector on the bus

  assign grant = pick_grant(pend, serv);
  assign grant_ok = grant[2] && chain_enable_in;
  assign serv_top = pick_grant(serv, 4'h0);
  assign interrupt_return_instruction_stb = fetch_end && ed_seen && (last_op == INTERRUPT_RETURN_INSTRUCTION_SECOND);

  // Pending and in-service flags; new zero count wins
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pend <= 4'h0;
      serv <= 4'h0;
    end else begin
      for (int c = 0; c < QCT_NCH; c++) begin
        if (zc[c] && setup[c].ie) begin
          pend[c] <= 1'b1;
        end else if (ack_stb && grant_ok && (grant[1:0] == 2'(c))) begin
          pend[c] <= 1'b0;
        end
        if (ack_stb && grant_ok && (grant[1:0] == 2'(c))) begin
          serv[c] <= 1'b1;
        end else if (interrupt_return_instruction_stb && serv_top[2] && (serv_top[1:0] == 2'(c))) begin
          serv[c] <= 1'b0;
        end
      end
    end
  end

  // Pending lets the chain through only on the fetch after the first byte
  assign chain_enable_out = chain_enable_in && !(|serv)
    && (!(|pend) || (ed_seen && fetch));
  assign int_req_n_out = 1'b0; // Open drain pulls low only
  assign int_req_n_oe = |pend;

  // ***************************************************
  // Data bus
  // ***************************************************
  logic rd_q; // Read drive

  // Read returns live count; acknowledge returns vector
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_out <= BYTE_RESET;
      rd_q <= 1'b0;
      ack_drive <= 1'b0;
    end else begin
      rd_q <= rd_act;
      if (rd_act) begin
        data_out <= count[sel];
      end else if (ack_stb && grant_ok) begin
        data_out <= {vector, grant[1:0], 1'b0};
      end
      if (ack_stb && grant_ok) begin
        ack_drive <= 1'b1;
      end else if (!ack_act) begin
        ack_drive <= 1'b0;
      end
    end
  end

  assign data_oe = rd_q || ack_drive;

  // ***************************************************
  // Checks
  // ***************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence s_ack_win;
    ack_stb && grant_ok;
  endsequence
  sequence s_vec_out;
    data_oe && (data_out[0] == 1'b0) && (data_out[7:3] == vector);
  endsequence

  a_tc_store: assert property (wr_stb && is_tc |=> reload_value[$past(sel)] == $past(host_bus.data))
    else $error("reload value not stored");
  a_presc_div: assert property (running[0] && !setup[0].counter_mode && !setup[0].pre256
    && presc[0] == PRE16_LAST && !wr_stb |=> presc[0] == BYTE_RESET)
    else $error("prescaler did not wrap at 16");
  a_zero_reload: assert property (zc[1] && !wr_stb |=> count[1] == $past(reload_value[1]))
    else $error("no reload at zero");
  a_zero_pulse: assert property (zc[0] |=> zero_count_pulse[0] ##1 (!zero_count_pulse[0]
    || $past(zc[0])))
    else $error("zero pulse wrong");
  a_irq_raise: assert property (zc[2] && setup[2].ie |=> int_req_n_oe)
    else $error("interrupt not requested");
  a_chain_block: assert property (|serv || !chain_enable_in |-> !chain_enable_out)
    else $error("chain not blocked");
  a_vec_drive: assert property (s_ack_win |=> s_vec_out and (data_out[2:1] == $past(grant[1:0])))
    else $error("vector not driven");
  a_soft_stop: assert property (wr_stb && is_ctl && host_bus.data[CW_SRST]
    |=> !running[$past(sel)] ##1 !running[$past(sel, 2)])
    else $error("channel not stopped");
  a_read_live: assert property (rd_act |=> data_oe && data_out == $past(count[sel]))
    else $error("read value wrong");
endmodule : qct_core

//--- test/qct_host_model.sv
// Host processor model: I/O writes and reads, acknowledge, return fetches.
// Assumes the block samples host_bus on the rising edge of sys_clk.
`timescale 1ns/10ps
module qct_host_model (
  input wire logic sys_clk,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  output qct_pkg::qct_bus_t host_bus
);
  import qct_pkg::*;
  // ***************************************************
  // Bus cycle engine
  // ***************************************************
  initial host_bus = {4'hf, 2'h0, 8'h5a}; // Idle, every strobe high
  // Strobes in order: chip enable, I/O request, read, opcode fetch
  // Held until the answer edge, so a slow block still sees a whole cycle
  task automatic cyc(input logic [3:0] stb, input logic [1:0] ch, input logic [7:0] d,
                     input int hold, output logic [7:0] q, output logic oe);
    @(posedge sys_clk);
    host_bus <= {stb, ch[1], ch[0], d};
    repeat (hold) @(posedge sys_clk);
    q = data_out; // Answer taken at the sampling edge
    oe = data_oe;
    host_bus <= {4'hf, ch, ~d}; // Released data shows no stale value
  endtask : cyc
  // One write cycle, read strobe high
  task automatic wr(input logic [1:0] ch, input logic [7:0] d);
    logic [7:0] q;
    logic oe;
    cyc(4'b0011, ch, d, 1, q, oe);
  endtask : wr
  // One read cycle of the live count
  task automatic rd(input logic [1:0] ch, output logic [7:0] q);
    logic oe;
    cyc(4'b0001, ch, 8'h3c, 2, q, oe);
  endtask : rd
  // Interrupt acknowledge: fetch and I/O request together
  task automatic ack(output logic [7:0] q, output logic oe);
    cyc(4'b1010, 2'h0, 8'hc3, 2, q, oe);
  endtask : ack
  // Two opcode fetches of the return instruction, then let it settle
  task automatic interrupt_return_instruction();
    logic [7:0] q;
    logic oe;
    cyc(4'b1100, 2'h0, INTERRUPT_RETURN_INSTRUCTION_FIRST, 2, q, oe);
    cyc(4'b1100, 2'h0, INTERRUPT_RETURN_INSTRUCTION_SECOND, 2, q, oe);
    repeat (3) @(posedge sys_clk);
  endtask : interrupt_return_instruction
endmodule : qct_host_model

//--- test/quad_counter_timer_daisy_irq_test.sv
// Self-checking bench for the four-channel counter/timer.
// Assumes qct_pkg, qct_core and the host model are compiled first.
`timescale 1ns/10ps
module quad_counter_timer_daisy_irq_test;
  import qct_pkg::*;
  logic sys_clk = 1'b0; // 200 MHz
  logic arst_n = 1'b0; // Held low at start
  logic [3:0] trig = 4'h0; // Trigger lines
  logic chain_in = 1'b1; // Daisy input
  qct_bus_t host_bus;
  logic [7:0] data_out;
  logic data_oe;
  logic irq_oe;
  logic irq_lvl; // Interrupt pin level while driven
  logic chain_out;
  logic [2:0] zcp;
  int zc [3]; // Zero pulses seen per channel
  int mismatches = 0;
  int comparisons = 0;
  logic [7:0] q;
  logic oe;
  int n;
  qct_core u_qct_core (.sys_clk(sys_clk), .arst_n(arst_n), .host_bus(host_bus),
    .data_out(data_out), .data_oe(data_oe), .ext_count_trigger(trig),
    .zero_count_pulse(zcp), .int_req_n_out(irq_lvl), .int_req_n_oe(irq_oe),
    .chain_enable_in(chain_in), .chain_enable_out(chain_out));
  qct_host_model u_h (.sys_clk(sys_clk), .data_out(data_out), .data_oe(data_oe),
    .host_bus(host_bus));
  // ***************************************************
  // Clock, pulse counting, watchdog
  // ***************************************************
  initial forever #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    for (int i = 0; i < 3; i++)
      if (zcp[i] === 1'b1) zc[i] <= zc[i] + 1;
  end
  // Whole run is under 2000 cycles, so this only cuts a hang
  initial begin
    repeat (6000) @(posedge sys_clk);
    mismatches++;
    print_verdict();
  end
  // ***************************************************
  // Helpers
  // ***************************************************
  task check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  // Pulse the chosen trigger lines high for one cycle
  task pulse(input logic [3:0] m);
    @(posedge sys_clk);
    trig <= m;
    @(posedge sys_clk);
    trig <= 4'h0;
    repeat (3) @(posedge sys_clk);
  endtask : pulse
  task print_verdict();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict
  // ***************************************************
  // Scenarios
  // ***************************************************
  // Outputs quiet in reset, chain output follows chain input
  task reset_case();
    repeat (3) @(posedge sys_clk);
    chain_in <= 1'b0;
    @(posedge sys_clk);
    check({5'h0, data_oe, irq_oe, chain_out}, 8'h00);
    check({5'h0, zcp}, 8'h00);
    chain_in <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check({7'h0, chain_out}, 8'h01);
    arst_n <= 1'b1;
  endtask : reset_case
  // Counter mode on channel 1: edges, reload, late reprogramming, 256
  task counter_case();
    u_h.wr(2'h1, 8'h55);
    u_h.wr(2'h1, 8'h03);
    u_h.rd(2'h1, q);
    check(q, 8'h03);
    pulse(4'h2);
    u_h.rd(2'h1, q);
    check(q, 8'h02);
    u_h.wr(2'h1, 8'h55);
    u_h.wr(2'h1, 8'h05);
    pulse(4'h2);
    u_h.rd(2'h1, q);
    check(q, 8'h01);
    pulse(4'h2);
    u_h.rd(2'h1, q);
    check(q, 8'h05);
    check(8'(zc[1]), 8'h01);
    u_h.wr(2'h1, 8'h55);
    u_h.wr(2'h1, 8'h00);
    repeat (5) pulse(4'h2);
    u_h.rd(2'h1, q);
    check(q, 8'h00);
    pulse(4'h2);
    u_h.rd(2'h1, q);
    check(q, 8'hff);
    check(8'(zc[0] + zc[2]), 8'h00);
  endtask : counter_case
  // Timer on channel 0: period, acknowledge, stop, return
  task timer_case(input logic [7:0] cw, input logic [7:0] tc, input int lo, input int hi,
                  input logic wait_trig);
    logic [7:0] c0;
    u_h.wr(2'h0, cw);
    u_h.wr(2'h0, tc);
    if (wait_trig) begin
      repeat (40) @(posedge sys_clk);
      check({7'h0, irq_oe}, 8'h00);
      pulse(4'h1);
    end
    n = 0;
    while (irq_oe !== 1'b1 && n < 600) begin
      @(posedge sys_clk);
      n++;
    end
    check({7'h0, n >= lo && n <= hi}, 8'h01);
    check({7'h0, chain_out}, 8'h00);
    check({7'h0, irq_lvl}, 8'h00);
    u_h.ack(q, oe);
    check(q, 8'ha8);
    u_h.wr(2'h0, 8'h03); // Stop, interrupt off
    u_h.interrupt_return_instruction();
    check({6'h0, irq_oe, chain_out}, 8'h01);
    u_h.rd(2'h0, c0);
    repeat (40) @(posedge sys_clk);
    u_h.rd(2'h0, q);
    check(q, c0);
  endtask : timer_case
  // Channels 2 and 3 at once: priority, blocking, chain input, enable
  task priority_case();
    u_h.wr(2'h2, 8'hd5);
    u_h.wr(2'h2, 8'h01);
    u_h.wr(2'h3, 8'hd5);
    u_h.wr(2'h3, 8'h01);
    pulse(4'hc);
    check({6'h0, irq_oe, chain_out}, 8'h02);
    u_h.ack(q, oe);
    check(q, 8'hac);
    u_h.ack(q, oe);
    check({7'h0, oe}, 8'h00);
    u_h.interrupt_return_instruction();
    u_h.ack(q, oe);
    check(q, 8'hae);
    u_h.interrupt_return_instruction();
    u_h.rd(2'h3, q);
    check(q, 8'h01);
    chain_in <= 1'b0;
    pulse(4'h4);
    check({7'h0, chain_out}, 8'h00);
    u_h.ack(q, oe);
    check({7'h0, oe}, 8'h00);
    chain_in <= 1'b1;
    u_h.ack(q, oe);
    check(q, 8'hac);
    u_h.interrupt_return_instruction();
    u_h.wr(2'h2, 8'h51); // Interrupt off, no reload
    pulse(4'h4);
    check({6'h0, irq_oe, chain_out}, 8'h01);
  endtask : priority_case
  // ***************************************************
  // Main sequence
  // ***************************************************
  initial begin
    reset_case();
    u_h.wr(2'h0, 8'ha8); // Shared vector, low bit clear
    counter_case();
    timer_case(8'h85, 8'h02, 28, 36, 1'b0);
    timer_case(8'ha5, 8'h01, 250, 262, 1'b0);
    timer_case(8'h8d, 8'h01, 10, 20, 1'b1);
    priority_case();
    print_verdict();
  end
endmodule : quad_counter_timer_daisy_irq_test
